// *** inc/tocpa_pkg.sv ***
// Package for the timer output-compare action and pulse accumulator block.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
// How it works
// RULE1: Eight compare channels, each with a mode bit and a level bit.
// RULE2: On compare: 00 nothing, 01 toggle, 10 clear, 11 set the channel output.
// RULE3: Mode or level bit set makes the channel pin an output of its compare line.
// RULE4: Software clears the channel-7 mask bit so mode and level bits steer the pin; the code only reads the channel-7 mask register back on the bus.
// RULE5: Compare logic drives a pin only while its disconnect bit is clear.
// RULE6: Accumulator enable starts the 16-bit accumulator, independent of timer enable.
// RULE7: The accumulator input is the channel 7 pin.
// RULE8: Mode bit: 0 event count, 1 gated time; mode and edge act only when enabled.
// RULE9: Event mode counts falling edges with edge 0, rising edges with edge 1.
// RULE10: Gated, edge 0: count bus clock over 64 while high; falling edge sets input flag.
// RULE11: Gated, edge 1: count bus clock over 64 while low; rising edge sets input flag.
// RULE12: Overflow flag with overflow interrupt enable raises an interrupt; the code also needs mask bit 1 set.
// RULE13: Input flag with input interrupt enable raises an interrupt; the code also needs mask bit 0 set.
// RULE14: Timer prescaler divides bus clock by 1 to 128 per three-bit select.
// RULE15: Wrap from maximum to zero sets overflow flag; each counted edge sets input flag.
// RULE16: Two clock-select bits pick the timer clock; zero selects the prescaled clock.
package tocpa_pkg;
    localparam logic [7:0]  ADDR_ACTION   = 8'h08;
    localparam logic [7:0]  ADDR_ACCCTRL  = 8'h20;
    localparam logic [7:0]  ADDR_ACCCOUNT = 8'h24;
    localparam logic [7:0]  ADDR_FLAGS    = 8'h28;
    localparam logic [7:0]  ADDR_MASK     = 8'h2c;
    localparam logic [7:0]  ADDR_DISCON   = 8'h30;
    localparam logic [7:0]  ADDR_CH7MASK  = 8'h34;
    localparam logic [7:0]  ADDR_PRESCALE = 8'h38;
    localparam logic [15:0] ACTION_RST    = 16'h0000;
    localparam logic [7:0]  ACCCTRL_RST   = 8'h00;
    localparam int          BIT_EN        = 6;
    localparam int          BIT_MODE      = 5;
    localparam int          BIT_EDGE      = 4;
    localparam int          BIT_CLK_LO    = 2;
    localparam int          BIT_OVI       = 1;
    localparam int          BIT_INI       = 0;
    localparam int          FLAG_OVF      = 1;
    localparam int          FLAG_INF      = 0;
    localparam int          GATE_DIV      = 64;
    typedef enum {ACT_NONE, ACT_TOGGLE, ACT_CLEAR, ACT_SET} tocpa_act_t;
endpackage : tocpa_pkg

// *** inc/tocpa_acc_if.sv ***
// Interface between the register front end and the accumulator core.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface tocpa_acc_if;
    logic        enable;
    logic        mode;
    logic        edge_sel;
    logic        load;
    logic [15:0] load_val;
    logic [15:0] count;
    logic        ovf_evt;
    logic        in_evt;
    logic        gate_tick;
    modport core (input enable, mode, edge_sel, load, load_val, output count, ovf_evt, in_evt, gate_tick);
    modport ctrl (output enable, mode, edge_sel, load, load_val, input count, ovf_evt, in_evt, gate_tick);
endinterface : tocpa_acc_if

// *** rtl/tocpa_accum.sv ***
// Pulse accumulator core fed from the channel 7 pin.
// Assumes the pin input is synchronous to clk_i.
`timescale 1ns/1ps
module tocpa_accum
    import tocpa_pkg::*;
#(
    parameter int WIDTH = 16
)(
    // Clock and reset
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    // Pin
    input  wire logic  pin_i,
    // Control and results
    tocpa_acc_if.core  acc
);
    import tocpa_pkg::*;
    logic [5:0]       div_q;
    logic             pin_q;
    logic [WIDTH-1:0] count_q;
    logic             rise;
    logic             fall;
    logic             tick;
    logic             inc;

    assign rise = pin_i & ~pin_q;
    assign fall = ~pin_i & pin_q;
    assign tick = (div_q == 6'(GATE_DIV - 1));

    always_comb
    begin
        inc = 1'b0;
        if (acc.enable) // [RULE6] [RULE8]
        begin
            if (!acc.mode)
                inc = acc.edge_sel ? rise : fall; // [RULE9]
            else
                inc = tick & (acc.edge_sel ? ~pin_i : pin_i); // [RULE10] [RULE11]
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            div_q <= 6'h00;
        else
            div_q <= div_q + 6'h01;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            pin_q <= 1'b0;
        else
            pin_q <= pin_i; // [RULE7]
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            count_q <= '0;
        else if (acc.load)
            count_q <= acc.load_val[WIDTH-1:0];
        else if (inc)
            count_q <= count_q + 1'b1;
    end

    assign acc.count     = count_q;
    assign acc.gate_tick = tick;
    assign acc.ovf_evt   = inc & ~acc.load & (&count_q); // [RULE15]
    assign acc.in_evt    = acc.enable & (acc.mode ? (acc.edge_sel ? rise : fall)
                                                  : (acc.edge_sel ? rise : fall)); // [RULE10] [RULE11] [RULE15]
endmodule : tocpa_accum

// *** rtl/tocpa_top.sv ***
// Top of the output-compare action and pulse accumulator block.
// Assumes classic Wishbone master; compare events arrive as one-cycle pulses.
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ps
module tocpa_top
    import tocpa_pkg::*;
#(
    parameter int CHANNELS = 8
)(
    // Clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    // Wishbone slave
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [7:0]          wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    // Compare events and timer pins
    input  wire logic [CHANNELS-1:0] compare_match_i,
    input  wire logic                channel7_pin_i,
    output logic      [CHANNELS-1:0] compare_channel_output_o,
    output logic      [CHANNELS-1:0] pin_oe_o,
    // Timer clocking
    input  wire logic                timer_global_enable_i,
    output logic                     timer_tick_o,
    // Interrupt
    output logic                     irq_o
);
    import tocpa_pkg::*;

    logic [15:0]         action_q;
    logic [7:0]          accctrl_q;
    logic [1:0]          flags_q;
    logic [1:0]          mask_q;
    logic [CHANNELS-1:0] discon_q;
    logic [CHANNELS-1:0] ch7mask_q;
    logic [2:0]          prescale_select_q;
    logic [6:0]          pre_cnt_q;
    logic [CHANNELS-1:0] oc_q;
    logic [31:0]         rdata_q;
    logic                ack_q;
    logic                acc_tick_q;
    logic                req;
    logic                wr;
    logic                pre_tick;
    logic [1:0]          clk_sel;
    logic [1:0]          flag_clr;

    tocpa_acc_if acc ();

    tocpa_accum #(.WIDTH(16)) u_accum (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .pin_i (channel7_pin_i),
        .acc   (acc)
    );

    // Two-bit field per channel; the 16-bit action register holds fields for eight channels only
    function automatic tocpa_act_t decode_act(input logic mode_bit, input logic level_bit);
        case ({mode_bit, level_bit})
            2'b00:   decode_act = ACT_NONE;
            2'b01:   decode_act = ACT_TOGGLE;
            2'b10:   decode_act = ACT_CLEAR;
            default: decode_act = ACT_SET;
        endcase
    endfunction : decode_act

    assign req = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr  = req & wb_we_i;

    assign acc.enable   = accctrl_q[BIT_EN];
    assign acc.mode     = accctrl_q[BIT_MODE];
    assign acc.edge_sel = accctrl_q[BIT_EDGE];
    assign acc.load     = wr && (wb_adr_i == ADDR_ACCCOUNT) && (wb_sel_i[1:0] == 2'b11);
    assign acc.load_val = wb_dat_i[15:0];

    // Control registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            action_q          <= ACTION_RST;
            accctrl_q         <= ACCCTRL_RST;
            mask_q            <= 2'b00;
            discon_q          <= '0;
            ch7mask_q         <= '0;
            prescale_select_q <= 3'h0;
        end
        else if (wr)
        begin
            if (wb_adr_i == ADDR_ACTION)
            begin
                if (wb_sel_i[0])
                    action_q[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1])
                    action_q[15:8] <= wb_dat_i[15:8];
            end
            else if (wb_adr_i == ADDR_ACCCTRL && wb_sel_i[0])
                accctrl_q <= {1'b0, wb_dat_i[6:0]};
            else if (wb_adr_i == ADDR_MASK && wb_sel_i[0])
                mask_q <= wb_dat_i[1:0];
            else if (wb_adr_i == ADDR_DISCON && wb_sel_i[0])
                discon_q <= wb_dat_i[CHANNELS-1:0];
            else if (wb_adr_i == ADDR_CH7MASK && wb_sel_i[0])
                ch7mask_q <= wb_dat_i[CHANNELS-1:0];
            else if (wb_adr_i == ADDR_PRESCALE && wb_sel_i[0])
                prescale_select_q <= wb_dat_i[2:0];
        end
    end

    // Sticky flags: hardware set wins over write-one clear
    assign flag_clr = (wr && wb_adr_i == ADDR_FLAGS && wb_sel_i[0]) ? wb_dat_i[1:0] : 2'b00;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            flags_q <= 2'b00;
        else
        begin
            flags_q[FLAG_OVF] <= acc.ovf_evt | (flags_q[FLAG_OVF] & ~flag_clr[FLAG_OVF]); // [RULE15]
            flags_q[FLAG_INF] <= acc.in_evt  | (flags_q[FLAG_INF] & ~flag_clr[FLAG_INF]); // [RULE10] [RULE11]
        end
    end

    // Interrupt enables live in the accumulator control bits, each also gated by its mask register bit
    assign irq_o = (flags_q[FLAG_OVF] & accctrl_q[BIT_OVI] & mask_q[FLAG_OVF])   // [RULE12]
                 | (flags_q[FLAG_INF] & accctrl_q[BIT_INI] & mask_q[FLAG_INF]);  // [RULE13]

    // Compare output actions per channel
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++)
        begin : g_ch
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                    oc_q[g] <= 1'b0;
                else if (compare_match_i[g])
                begin
                    case (decode_act(action_q[2*g+1], action_q[2*g])) // [RULE1] [RULE2]
                        ACT_TOGGLE: oc_q[g] <= ~oc_q[g];
                        ACT_CLEAR:  oc_q[g] <= 1'b0;
                        ACT_SET:    oc_q[g] <= 1'b1;
                        default:    oc_q[g] <= oc_q[g];
                    endcase
                end
            end
            // Channel-7 mask ownership left to software
            assign pin_oe_o[g] = (action_q[2*g+1] | action_q[2*g]) & ~discon_q[g]; // [RULE3] [RULE5] [RULE4]
        end
    endgenerate

    assign compare_channel_output_o = oc_q;

    // Prescaler
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            pre_cnt_q <= 7'h00;
        else if (timer_global_enable_i)
            pre_cnt_q <= pre_cnt_q + 7'h01;
    end

    always_comb
    begin
        pre_tick = 1'b0;
        if (timer_global_enable_i)
        begin
            case (prescale_select_q) // [RULE14]
                3'h0:    pre_tick = 1'b1;
                3'h1:    pre_tick = &pre_cnt_q[0:0];
                3'h2:    pre_tick = &pre_cnt_q[1:0];
                3'h3:    pre_tick = &pre_cnt_q[2:0];
                3'h4:    pre_tick = &pre_cnt_q[3:0];
                3'h5:    pre_tick = &pre_cnt_q[4:0];
                3'h6:    pre_tick = &pre_cnt_q[5:0];
                default: pre_tick = &pre_cnt_q[6:0];
            endcase
        end
    end

    // Timer clock selection
    assign clk_sel = accctrl_q[BIT_CLK_LO+1:BIT_CLK_LO];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            acc_tick_q <= 1'b0;
        else
        begin
            case (clk_sel) // [RULE16]
                2'b00:   acc_tick_q <= pre_tick;
                2'b01:   acc_tick_q <= acc.gate_tick & timer_global_enable_i;
                2'b10:   acc_tick_q <= acc.ovf_evt & timer_global_enable_i;
                default: acc_tick_q <= acc.in_evt & timer_global_enable_i;
            endcase
        end
    end

    assign timer_tick_o = acc_tick_q;

    // Read data and acknowledge
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rdata_q <= 32'h0000_0000;
        else if (req)
        begin
            if (wb_adr_i == ADDR_ACTION)
                rdata_q <= {16'h0000, action_q};
            else if (wb_adr_i == ADDR_ACCCTRL)
                rdata_q <= {24'h000000, accctrl_q};
            else if (wb_adr_i == ADDR_ACCCOUNT)
                rdata_q <= {16'h0000, acc.count};
            else if (wb_adr_i == ADDR_FLAGS)
                rdata_q <= {30'h0, flags_q};
            else if (wb_adr_i == ADDR_MASK)
                rdata_q <= {30'h0, mask_q};
            else if (wb_adr_i == ADDR_DISCON)
                rdata_q <= {{(32-CHANNELS){1'b0}}, discon_q};
            else if (wb_adr_i == ADDR_CH7MASK)
                rdata_q <= {{(32-CHANNELS){1'b0}}, ch7mask_q};
            else if (wb_adr_i == ADDR_PRESCALE)
                rdata_q <= {29'h0, prescale_select_q};
            else
                rdata_q <= 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_q <= 1'b0;
        else
            ack_q <= req;
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;
endmodule : tocpa_top

// *** test/tocpa_pin_model.sv ***
// Far-side model of the channel 7 timer pin.
// Assumes the pin is sampled on the rising edge of clk_i.
`timescale 1ns/1ps
module tocpa_pin_model (
    // Clock
    input  wire logic clk_i,
    // Pin
    output logic      pin_o
);
    initial pin_o = 1'b0;
    // Hold a level for a number of cycles, so pulses can be short or long
    task automatic drive(input logic lvl, input int cycles);
        @(posedge clk_i);
        pin_o <= lvl;
        repeat (cycles) @(posedge clk_i);
    endtask : drive
    task automatic pulses(input int cnt, input int width);
        repeat (cnt)
        begin
            drive(1'b1, width);
            drive(1'b0, width);
        end
    endtask : pulses
endmodule : tocpa_pin_model

// *** test/tocpa_monitor.sv ***
// Port checker for the compare action and accumulator block.
// Assumes it is bound to tocpa_top and sees its ports only.
`timescale 1ns/1ps
module tocpa_monitor
    import tocpa_pkg::*;
#(
    parameter int CHANNELS = 8
)(
    // Clock and reset
    input wire logic                clk_i,
    input wire logic                rst_i,
    // Bus
    input wire logic                wb_cyc_i,
    input wire logic                wb_stb_i,
    input wire logic                wb_we_i,
    input wire logic [7:0]          wb_adr_i,
    input wire logic [31:0]         wb_dat_o,
    input wire logic                wb_ack_o,
    // Channels and interrupt
    input wire logic [CHANNELS-1:0] compare_match_i,
    input wire logic [CHANNELS-1:0] compare_channel_output_o,
    input wire logic [CHANNELS-1:0] pin_oe_o,
    input wire logic                irq_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic req;
    logic wr;
    assign req = wb_cyc_i && wb_stb_i;
    assign wr  = req && wb_we_i;
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_after_req: assert property (req && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked in one cycle");
    a_no_idle_ack: assert property (!req |=> !wb_ack_o)
        else $error("ack without request");
    a_read_data_hold: assert property (!req |=> $stable(wb_dat_o))
        else $error("read data moved while idle");
    a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h00 |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_oe_by_write: assert property (!(wr && (wb_adr_i == ADDR_ACTION || wb_adr_i == ADDR_DISCON)) |=> $stable(pin_oe_o))
        else $error("pin enable changed without write");
    a_out_by_match: assert property (((compare_channel_output_o ^ $past(compare_channel_output_o)) & ~$past(compare_match_i)) == '0)
        else $error("channel output changed without match");
    a_irq_fall_write: assert property ($fell(irq_o) && !$past(rst_i) |-> $past(wr))
        else $error("interrupt dropped without write");
    c_read: cover property (wb_ack_o && !wb_we_i);
    c_irq: cover property ($rose(irq_o));
    c_out: cover property (|compare_match_i ##1 $changed(compare_channel_output_o));
endmodule : tocpa_monitor
bind tocpa_top tocpa_monitor #(.CHANNELS(CHANNELS)) u_mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .compare_match_i(compare_match_i), .compare_channel_output_o(compare_channel_output_o),
    .pin_oe_o(pin_oe_o), .irq_o(irq_o));

// *** test/tb_top.sv ***
// Self-checking bench for the compare action and accumulator block.
// Assumes the pin model drives channel 7 and the port checker is bound.
`timescale 1ns/1ps
module tb_top;
    import tocpa_pkg::*;
    logic        clk_i;
    logic        rst_i;
    logic        cyc;
    logic        stb;
    logic        we;
    logic        ack;
    logic        irq;
    logic        tick;
    logic        tge;
    logic        pin;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic [7:0]  match;
    logic [7:0]  out;
    logic [7:0]  oe;
    logic [7:0]  exp_out;
    logic [15:0] act;
    logic [31:0] exp_q[$];
    int          failures;
    int          samples_checked;
    int          seed;
    int          n;
    int          ticks;
    tocpa_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .compare_match_i(match), .channel7_pin_i(pin), .compare_channel_output_o(out),
        .pin_oe_o(oe), .timer_global_enable_i(tge), .timer_tick_o(tick), .irq_o(irq));
    tocpa_pin_model pm (.clk_i(clk_i), .pin_o(pin));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic end_sim;
        $display("Checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int k;
        k = 0;
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= s;
        wdat <= d;
        do
        begin
            @(posedge clk_i);
            k++;
        end
        while (ack !== 1'b1 && k < 20);
        check("ack", {31'h0, ack}, 32'h1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 4'hf);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        xfer(1'b0, a, 32'h0, 4'hf);
    endtask : rd
    task automatic tk(input int c);
        repeat (c) @(posedge clk_i);
    endtask : tk
    function automatic logic [7:0] predict(input logic [15:0] a, input logic [7:0] m, input logic [7:0] o);
        for (int g = 0; g < 8; g++)
            if (m[g])
                case (a[2*g+:2])
                    2'b01: o[g] = ~o[g];
                    2'b10: o[g] = 1'b0;
                    2'b11: o[g] = 1'b1;
                    default: o[g] = o[g];
                endcase
        return o;
    endfunction : predict
    function automatic logic [7:0] oe_of(input logic [15:0] a);
        for (int g = 0; g < 8; g++)
            oe_of[g] = a[2*g] | a[2*g+1];
    endfunction : oe_of
    task automatic fire(input logic [7:0] m);
        @(posedge clk_i);
        match <= m;
        @(posedge clk_i);
        match <= 8'h00;
        exp_out = predict(act, m, exp_out);
        @(posedge clk_i);
        check("compare output", {24'h0, out}, {24'h0, exp_out});
    endtask : fire
    // Running count of timer ticks, updated after the edge so readers see a settled value
    always @(posedge clk_i)
        ticks <= ticks + int'(tick === 1'b1);
    // Oldest expected read value is compared when a read is acked
    always @(posedge clk_i)
        if (ack === 1'b1 && we === 1'b0)
            check("read data", rdat, exp_q.pop_front());
    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    initial
    begin
        #1000000;
        failures++;
        end_sim();
    end
    initial
    begin
        seed = 32'h1500ab97;
        {cyc, stb, we, match, tge, adr, sel, wdat, exp_out, act} = '0;
        ticks = 0;
        rst_i = 1'b1;
        tk(10);
        rst_i <= 1'b0;
        rd(ADDR_ACCCTRL, 32'h0);
        rd(ADDR_ACTION, 32'h0);
        wr(8'h00, 32'hffff);
        rd(8'h00, 32'h0);
        wr(ADDR_ACCCTRL, 32'hff);
        rd(ADDR_ACCCTRL, 32'h7f);
        wr(ADDR_ACCCTRL, 32'h0);
        wr(ADDR_CH7MASK, 32'h0);
        for (int i = 0; i < 8; i++)
        begin
            act = (i == 0) ? 16'he4e4 : 16'($random(seed));
            wr(ADDR_ACTION, {16'h0, act});
            tk(1);
            check("pin enable", {24'h0, oe}, {24'h0, oe_of(act)});
            fire((i == 0) ? 8'hff : 8'($random(seed)));
        end
        rd(ADDR_ACTION, {16'h0, act});
        wr(ADDR_DISCON, 32'h0f);
        tk(1);
        check("pin enable", {24'h0, oe}, {24'h0, oe_of(act) & 8'hf0});
        tge <= 1'b1;
        for (int s = 0; s < 8; s++)
        begin
            wr(ADDR_PRESCALE, 32'(s));
            tk(4);
            n = 0;
            repeat (256)
            begin
                @(posedge clk_i);
                n += (tick === 1'b1);
            end
            check("timer ticks", 32'(n), 32'(256 >> s));
        end
        tge <= 1'b0;
        wr(ADDR_ACCCOUNT, 32'h0);
        wr(ADDR_FLAGS, 32'h3);
        wr(ADDR_MASK, 32'h1);
        wr(ADDR_ACCCTRL, 32'h41);
        pm.pulses(3, 2);
        rd(ADDR_ACCCOUNT, 32'h3);
        rd(ADDR_FLAGS, 32'h1);
        tk(1);
        check("irq", {31'h0, irq}, 32'h1);
        wr(ADDR_ACCCTRL, 32'h40);
        tk(1);
        check("irq", {31'h0, irq}, 32'h0);
        wr(ADDR_ACCCOUNT, 32'h0);
        wr(ADDR_ACCCTRL, 32'h50);
        pm.pulses(2, 5);
        rd(ADDR_ACCCOUNT, 32'h2);
        wr(ADDR_ACCCTRL, 32'h10);
        pm.pulses(2, 1);
        rd(ADDR_ACCCOUNT, 32'h2);
        wr(ADDR_ACCCOUNT, 32'hffff);
        wr(ADDR_FLAGS, 32'h3);
        wr(ADDR_MASK, 32'h3);
        wr(ADDR_ACCCTRL, 32'h52);
        pm.pulses(1, 1);
        rd(ADDR_ACCCOUNT, 32'h0);
        rd(ADDR_FLAGS, 32'h3);
        tk(1);
        check("irq", {31'h0, irq}, 32'h1);
        wr(ADDR_ACCCTRL, 32'h50);
        tk(1);
        check("irq", {31'h0, irq}, 32'h0);
        wr(ADDR_ACCCTRL, 32'h60);
        wr(ADDR_ACCCOUNT, 32'h0);
        wr(ADDR_FLAGS, 32'h3);
        pm.drive(1'b1, 255);
        pm.drive(1'b0, 4);
        rd(ADDR_ACCCOUNT, 32'h4);
        rd(ADDR_FLAGS, 32'h1);
        pm.drive(1'b1, 3);
        wr(ADDR_ACCCTRL, 32'h70);
        wr(ADDR_ACCCOUNT, 32'h0);
        wr(ADDR_FLAGS, 32'h3);
        pm.drive(1'b0, 127);
        pm.drive(1'b1, 4);
        rd(ADDR_ACCCOUNT, 32'h2);
        rd(ADDR_FLAGS, 32'h1);
        pm.drive(1'b0, 2);
        tge <= 1'b1;
        wr(ADDR_ACCCTRL, 32'h5c);
        n = ticks;
        pm.pulses(3, 2);
        tk(2);
        check("event ticks", 32'(ticks - n), 32'h3);
        wr(ADDR_ACCCTRL, 32'h44);
        tk(1);
        n = ticks;
        tk(256);
        check("gate ticks", 32'(ticks - n), 32'h4);
        wr(ADDR_ACCCOUNT, 32'hffff);
        wr(ADDR_ACCCTRL, 32'h58);
        n = ticks;
        pm.pulses(1, 1);
        tk(2);
        check("overflow ticks", 32'(ticks - n), 32'h1);
        xfer(1'b1, ADDR_ACCCOUNT, 32'h1234, 4'h1);
        rd(ADDR_ACCCOUNT, 32'h0);
        tk(4);
        end_sim();
    end
endmodule : tb_top
